// [rtl/rfh_device.sv]
// Message centers with remote frame send, match, store and automatic reply
// What this block does
// R1 - Lowest ready receive center with request sends remote
// R2 - Clear request on success; rescan from lowest center
// R3 - Remote request send ignores transmit inhibit
// R4 - Incoming remote: zero data, set pending, receive success
// R5 - First matching ready center, ascending, masked, wins
// R6 - Store requested byte count, set pending flag
// R7 - Receive interrupt after store when enabled
// R8 - Software keeps or clears pending flag
// R9 - Software: disable, configure, receive, then request
// R10 - Remote sent: clear request, transmit success, interrupt
// R11 - Only centers one to fourteen send remotes
// R12 - Transmit center: request sets pending and request
// R13 - Reply sent: success, clear pending and request
// R14 - Inhibit accepts request but holds reply
// R15 - Software gates data edits with inhibit, updated
// R16 - Reply needs updated set and inhibit clear
// R17 - Software disables center before identity changes
// R18 - Receive center: count, pending, no request, no reply
// R19 - Receive center acceptance also sets data updated
// R20 - Software clears receive success beforehand
// R21 - Software sequence for automatic reply setup
// R22 - Software sequence for same-center reply
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rfh_map.svh"
module rfh_device import rfh_pkg::*; #(
	parameter int NC = `RFH_NUM_CENTERS
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	rfh_if.dev bus,
	input wire logic i_rx_valid,
	input wire logic [28:0] i_rx_id,
	input wire logic i_rx_ext,
	input wire logic i_rx_rtr,
	input wire logic [3:0] i_rx_dlc,
	output logic o_tx_valid,
	output logic [3:0] o_tx_center,
	output logic [28:0] o_tx_id,
	output logic o_tx_ext,
	output logic o_tx_rtr,
	output logic [3:0] o_tx_dlc,
	input wire logic i_tx_done,
	input wire logic i_tx_ok
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	// Software write image replaces control bits; identifier kept
	function automatic rfh_center_t word_to_center(input logic [31:0] w,
			input logic [28:0] id);
		rfh_center_t c;
		c.ready = w[`RFH_B_READY];
		c.treq = w[`RFH_B_TREQ];
		c.transmit_inhibit = w[`RFH_B_TIH];
		c.data_updated = w[`RFH_B_DATA_UPDATED];
		c.remote_request_pending = w[`RFH_B_REMOTE_REQUEST_PENDING];
		c.dir = w[`RFH_B_DIR];
		c.receive_success_flag = w[`RFH_B_RXS];
		c.transmit_success_flag = w[`RFH_B_TXS];
		c.receive_interrupt_enable = w[`RFH_B_ERI];
		c.transmit_interrupt_enable = w[`RFH_B_ETI];
		c.center_interrupt_request = w[`RFH_B_CENTER_INTERRUPT_REQUEST];
		c.ext = w[`RFH_B_EXT];
		c.id_mask_enable = w[`RFH_B_ID_MASK_ENABLE];
		c.dlc = w[`RFH_B_DLC_HI:`RFH_B_DLC_LO];
		c.id = id;
		return c;
	endfunction

	// Control bits as software reads them; unused bits zero
	function automatic logic [31:0] center_to_word(input rfh_center_t c);
		logic [31:0] w;
		w = 32'h00000000;
		w[`RFH_B_READY] = c.ready;
		w[`RFH_B_TREQ] = c.treq;
		w[`RFH_B_TIH] = c.transmit_inhibit;
		w[`RFH_B_DATA_UPDATED] = c.data_updated;
		w[`RFH_B_REMOTE_REQUEST_PENDING] = c.remote_request_pending;
		w[`RFH_B_DIR] = c.dir;
		w[`RFH_B_RXS] = c.receive_success_flag;
		w[`RFH_B_TXS] = c.transmit_success_flag;
		w[`RFH_B_ERI] = c.receive_interrupt_enable;
		w[`RFH_B_ETI] = c.transmit_interrupt_enable;
		w[`RFH_B_CENTER_INTERRUPT_REQUEST] = c.center_interrupt_request;
		w[`RFH_B_EXT] = c.ext;
		w[`RFH_B_ID_MASK_ENABLE] = c.id_mask_enable;
		w[`RFH_B_DLC_HI:`RFH_B_DLC_LO] = c.dlc;
		return w;
	endfunction

	// Mask in force: global mask when enabled, trimmed to standard width for standard frames
	function automatic logic [28:0] eff_mask(input rfh_center_t c,
			input logic [28:0] gm);
		logic [28:0] m;
		m = c.id_mask_enable ? gm : `RFH_RST_MASK;
		if (!c.ext) begin
			m = m & `RFH_STD_ID_MASK;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	rfh_center_t mc_ff [NC];
	rfh_center_t nxt_mc [NC];
	rfh_tx_state_t tx_state_ff;
	logic [3:0] tx_idx_ff;
	logic tx_is_reply_ff;
	logic rx_hit;
	logic [3:0] rx_idx;
	logic tx_hit;
	logic [3:0] tx_idx;
	logic tx_fin;

	assign tx_fin = (tx_state_ff == RFH_TX_BUSY) && i_tx_done;

	// Incoming frame: first ready center in ascending order that matches
	always_comb begin
		rx_hit = 1'b0;
		rx_idx = 4'h0;
		for (int i = 0; i < NC; i++) begin
			if (!rx_hit && mc_ff[i].ready && (mc_ff[i].ext == i_rx_ext) && // R5
					(((i_rx_id ^ mc_ff[i].id) & eff_mask(mc_ff[i], bus.gmask)) == 29'h0) &&
					(i_rx_rtr || !mc_ff[i].dir)) begin
				rx_hit = 1'b1; // R5
				rx_idx = 4'(i);
			end
		end
	end

	// Transmit scan from the lowest center; remote sends ignore inhibit
	always_comb begin
		tx_hit = 1'b0;
		tx_idx = 4'h0;
		for (int i = 0; i < NC; i++) begin
			if (!tx_hit && mc_ff[i].ready && mc_ff[i].treq) begin
				if (!mc_ff[i].dir && (i < `RFH_LAST_REQ_CENTER)) begin // R1 R3 R11
					tx_hit = 1'b1;
					tx_idx = 4'(i);
				end else if (mc_ff[i].dir && !mc_ff[i].transmit_inhibit && mc_ff[i].data_updated) begin // R16 R14
					tx_hit = 1'b1;
					tx_idx = 4'(i);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next center state; hardware sets land after the software write so they win
	always_comb begin
		for (int i = 0; i < NC; i++) begin
			nxt_mc[i] = mc_ff[i];
			if (bus.cfg_wr && (bus.cfg_sel == 4'(i + 1))) begin
				nxt_mc[i] = word_to_center(bus.cfg_wdata, mc_ff[i].id);
			end
			if (bus.id_wr && (bus.cfg_sel == 4'(i + 1))) begin
				nxt_mc[i].id = bus.id_wdata;
			end
			// Transmit outcome; lost arbitration and errors leave request set
			if (tx_fin && i_tx_ok && (tx_idx_ff == 4'(i))) begin
				nxt_mc[i].treq = 1'b0; // R2 R10 R13
				nxt_mc[i].transmit_success_flag = 1'b1; // R10 R13
				if (mc_ff[i].transmit_interrupt_enable) begin
					nxt_mc[i].center_interrupt_request = 1'b1; // R10 R13
				end
				if (tx_is_reply_ff) begin
					nxt_mc[i].remote_request_pending = 1'b0; // R13 R16
				end
			end
			// Frame stored; a remote request stores its requested byte count
			if (i_rx_valid && rx_hit && (rx_idx == 4'(i))) begin
				nxt_mc[i].receive_success_flag = 1'b1; // R4
				nxt_mc[i].dlc = i_rx_dlc; // R6
				nxt_mc[i].id = i_rx_id & eff_mask(mc_ff[i], bus.gmask);
				if (mc_ff[i].receive_interrupt_enable) begin
					nxt_mc[i].center_interrupt_request = 1'b1; // R7
				end
				if (i_rx_rtr) begin
					nxt_mc[i].remote_request_pending = 1'b1; // R4 R6
					if (mc_ff[i].dir) begin
						nxt_mc[i].treq = 1'b1; // R12 R14
					end else begin
						nxt_mc[i].data_updated = 1'b1; // R18 R19
					end
				end else begin
					nxt_mc[i].data_updated = 1'b1; // R19
				end
			end
		end
	end

	// Center registers
	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < NC; i++) begin
			if (i_reset) begin
				mc_ff[i] <= '0;
			end else begin
				mc_ff[i] <= nxt_mc[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit scheduler: one frame at a time, rescan after every outcome
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			tx_state_ff <= RFH_TX_IDLE;
			tx_idx_ff <= 4'h0;
			tx_is_reply_ff <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_center <= 4'h0;
			o_tx_id <= 29'h0;
			o_tx_ext <= 1'b0;
			o_tx_rtr <= 1'b0;
			o_tx_dlc <= 4'h0;
		end else begin
			case (tx_state_ff)
				RFH_TX_IDLE: begin
					// Copy the chosen center into the transmit buffer
					if (tx_hit) begin
						tx_state_ff <= RFH_TX_BUSY; // R1
						tx_idx_ff <= tx_idx;
						tx_is_reply_ff <= mc_ff[tx_idx].dir;
						o_tx_valid <= 1'b1;
						o_tx_center <= tx_idx + 4'h1;
						o_tx_id <= mc_ff[tx_idx].id;
						o_tx_ext <= mc_ff[tx_idx].ext;
						o_tx_rtr <= !mc_ff[tx_idx].dir;
						o_tx_dlc <= mc_ff[tx_idx].dlc; // R6
					end
				end
				RFH_TX_BUSY: begin
					// Idle one cycle so the scan sees updated flags
					if (i_tx_done) begin
						tx_state_ff <= RFH_TX_IDLE; // R2
						o_tx_valid <= 1'b0;
					end
				end
				default: begin
					tx_state_ff <= RFH_TX_IDLE;
					o_tx_valid <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readback of the selected center and the interrupt lines
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset && (bus.cfg_sel != 4'h0) && (bus.cfg_sel <= 4'(NC))) begin
			bus.rd_word <= center_to_word(mc_ff[bus.cfg_sel - 4'h1]);
			bus.rd_id <= mc_ff[bus.cfg_sel - 4'h1].id;
		end else begin
			bus.rd_word <= 32'h00000000;
			bus.rd_id <= 29'h0;
		end
	end

	// Interrupt request flags per center; software clears via control word
	always_ff @(posedge i_clk_sys) begin
		for (int i = 0; i < 15; i++) begin
			if (i_reset || (i >= NC)) begin
				bus.center_interrupt_request[i] <= 1'b0;
			end else begin
				bus.center_interrupt_request[i] <= mc_ff[i].center_interrupt_request; // R7
			end
		end
	end

endmodule
`default_nettype wire

// [rtl/rfh_host.sv]
// Host controller end: AXI4-Lite slave that drives message-center writes
`timescale 1ns/100ps
`default_nettype none
`include "rfh_map.svh"
module rfh_host import rfh_pkg::*; #(
	parameter int AW = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	rfh_if.ctl bus,
	input wire logic i_s_awvalid,
	output logic o_s_awready,
	input wire logic [AW-1:0] i_s_awaddr,
	input wire logic i_s_wvalid,
	output logic o_s_wready,
	input wire logic [31:0] i_s_wdata,
	input wire logic [3:0] i_s_wstrb,
	output logic o_s_bvalid,
	input wire logic i_s_bready,
	output logic [1:0] o_s_bresp,
	input wire logic i_s_arvalid,
	output logic o_s_arready,
	input wire logic [AW-1:0] i_s_araddr,
	output logic o_s_rvalid,
	input wire logic i_s_rready,
	output logic [31:0] o_s_rdata,
	output logic [1:0] o_s_rresp
);

	// Byte-lane merge of a write into a current value
	function automatic logic [31:0] merge(input logic [31:0] cur,
			input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = cur;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic aw_got_ff;
	logic w_got_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;
	logic [7:0] wa;
	logic [7:0] ra;
	logic [31:0] id_mrg;
	logic [31:0] sel_mrg;
	logic [31:0] mask_mrg;

	// Merged images kept whole so that the narrow targets take a plain part-select
	assign id_mrg = merge({3'b000, bus.rd_id}, wdata_ff, wstrb_ff);
	assign sel_mrg = merge({28'h0, bus.cfg_sel}, wdata_ff, wstrb_ff);
	assign mask_mrg = merge({3'b000, bus.gmask}, wdata_ff, wstrb_ff);
	assign do_write = aw_got_ff && w_got_ff && !o_s_bvalid;
	assign wa = awaddr_ff;
	assign ra = 8'(i_s_araddr) & 8'hFC;

	////////////////////////////////////////////////////////////////////////////
	// Write channels, taken in either order; response after both

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			o_s_awready <= 1'b1;
			o_s_wready <= 1'b1;
			o_s_bvalid <= 1'b0;
			o_s_bresp <= `RFH_RESP_OKAY;
		end else begin
			if (i_s_awvalid && o_s_awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= 8'(i_s_awaddr) & 8'hFC;
				o_s_awready <= 1'b0;
			end
			if (i_s_wvalid && o_s_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= i_s_wdata;
				wstrb_ff <= i_s_wstrb;
				o_s_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				o_s_bvalid <= 1'b1;
				o_s_bresp <= (wa <= `RFH_OFF_MASK) ? `RFH_RESP_OKAY : `RFH_RESP_SLVERR;
			end
			if (o_s_bvalid && i_s_bready) begin
				o_s_bvalid <= 1'b0;
				o_s_awready <= 1'b1;
				o_s_wready <= 1'b1;
			end
		end
	end

	// Register effects: selection, mask, and one-cycle orders to the centers
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			bus.cfg_sel <= 4'h0;
			bus.gmask <= `RFH_RST_MASK;
			bus.cfg_wr <= 1'b0;
			bus.cfg_wdata <= 32'h00000000;
			bus.id_wr <= 1'b0;
			bus.id_wdata <= 29'h0;
		end else begin
			bus.cfg_wr <= do_write && (wa == `RFH_OFF_CTRL); // R9 R15 R21 R22
			bus.id_wr <= do_write && (wa == `RFH_OFF_ID); // R17
			if (do_write && (wa == `RFH_OFF_CTRL)) begin
				bus.cfg_wdata <= merge(bus.rd_word, wdata_ff, wstrb_ff);
			end
			if (do_write && (wa == `RFH_OFF_ID)) begin
				bus.id_wdata <= id_mrg[28:0];
			end
			if (do_write && (wa == `RFH_OFF_SEL)) begin
				bus.cfg_sel <= sel_mrg[3:0];
			end
			if (do_write && (wa == `RFH_OFF_MASK)) begin
				bus.gmask <= mask_mrg[28:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel: data one cycle after the address is taken

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_s_arready <= 1'b1;
			o_s_rvalid <= 1'b0;
			o_s_rdata <= 32'h00000000;
			o_s_rresp <= `RFH_RESP_OKAY;
		end else begin
			if (i_s_arvalid && o_s_arready) begin
				o_s_arready <= 1'b0;
				o_s_rvalid <= 1'b1;
				o_s_rresp <= `RFH_RESP_OKAY;
				case (ra)
					`RFH_OFF_SEL: o_s_rdata <= {28'h0, bus.cfg_sel};
					`RFH_OFF_CTRL: o_s_rdata <= bus.rd_word; // R8 R20
					`RFH_OFF_ID: o_s_rdata <= {3'b000, bus.rd_id};
					`RFH_OFF_MASK: o_s_rdata <= {3'b000, bus.gmask};
					`RFH_OFF_INTP: o_s_rdata <= {17'h0, bus.center_interrupt_request};
					default: begin
						o_s_rdata <= 32'h00000000;
						o_s_rresp <= `RFH_RESP_SLVERR;
					end
				endcase
			end
			if (o_s_rvalid && i_s_rready) begin
				o_s_rvalid <= 1'b0;
				o_s_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// [rtl/rfh_if.sv]
// Carrier between the host controller end and the message-center end
`timescale 1ns/100ps
`default_nettype none
interface rfh_if;
	logic [3:0] cfg_sel;
	logic cfg_wr;
	logic [31:0] cfg_wdata;
	logic id_wr;
	logic [28:0] id_wdata;
	logic [28:0] gmask;
	logic [31:0] rd_word;
	logic [28:0] rd_id;
	logic [14:0] center_interrupt_request;

	modport dev (
		input cfg_sel, cfg_wr, cfg_wdata, id_wr, id_wdata, gmask,
		output rd_word, rd_id, center_interrupt_request
	);
	modport ctl (
		output cfg_sel, cfg_wr, cfg_wdata, id_wr, id_wdata, gmask,
		input rd_word, rd_id, center_interrupt_request
	);
endinterface
`default_nettype wire

// [rtl/rfh_map.svh]
// Offsets, control-word fields, reset values and counts for the remote frame handler
`ifndef RFH_MAP_SVH
`define RFH_MAP_SVH

// Message centers 1..15, the last sends no remote requests
`define RFH_NUM_CENTERS 15
`define RFH_LAST_REQ_CENTER 14

// Control word bit positions
`define RFH_B_READY 0
`define RFH_B_TREQ 1
`define RFH_B_TIH 2
`define RFH_B_DATA_UPDATED 3
`define RFH_B_REMOTE_REQUEST_PENDING 4
`define RFH_B_DIR 5
`define RFH_B_RXS 6
`define RFH_B_TXS 7
`define RFH_B_ERI 8
`define RFH_B_ETI 9
`define RFH_B_CENTER_INTERRUPT_REQUEST 10
`define RFH_B_EXT 11
`define RFH_B_ID_MASK_ENABLE 12
`define RFH_B_DLC_LO 16
`define RFH_B_DLC_HI 19

// Host register byte offsets
`define RFH_OFF_SEL 8'h00
`define RFH_OFF_CTRL 8'h04
`define RFH_OFF_ID 8'h08
`define RFH_OFF_MASK 8'h0C
`define RFH_OFF_INTP 8'h10

// Reset value of the global mask, and the standard identifier mask
`define RFH_RST_MASK 29'h1FFFFFFF
`define RFH_STD_ID_MASK 29'h000007FF

// AXI response codes
`define RFH_RESP_OKAY 2'h0
`define RFH_RESP_SLVERR 2'h2

`endif

// [rtl/rfh_pkg.sv]
// Types shared by both ends of the remote frame handler
`default_nettype none
package rfh_pkg;

	// Transmit scheduler states, Gray along idle -> busy
	typedef enum logic [1:0] {
		RFH_TX_IDLE = 2'b00,
		RFH_TX_BUSY = 2'b01
	} rfh_tx_state_t;

	// One message center's control, status and arbitration state
	typedef struct packed {
		logic ready;
		logic treq;
		logic transmit_inhibit;
		logic data_updated;
		logic remote_request_pending;
		logic dir;
		logic receive_success_flag;
		logic transmit_success_flag;
		logic receive_interrupt_enable;
		logic transmit_interrupt_enable;
		logic center_interrupt_request;
		logic ext;
		logic id_mask_enable;
		logic [3:0] dlc;
		logic [28:0] id;
	} rfh_center_t;

endpackage
`default_nettype wire

// [test/rfh_chk.sv]
// Concurrent checks on the carrier and frame ports of the remote frame handler
`timescale 1ns/100ps
`default_nettype none
module rfh_chk (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic cfg_wr,
	input wire logic [3:0] cfg_sel,
	input wire logic [31:0] cfg_wdata,
	input wire logic [28:0] gmask,
	input wire logic [31:0] rd_word,
	input wire logic [14:0] center_interrupt_request,
	input wire logic i_rx_valid,
	input wire logic i_tx_done,
	input wire logic o_tx_valid,
	input wire logic [3:0] o_tx_center,
	input wire logic [28:0] o_tx_id,
	input wire logic o_tx_rtr,
	input wire logic [3:0] o_tx_dlc
);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (i_reset);

// Anything that may raise a center flag; the flag shows two edges later
logic cause;
logic [3:0] wr_dlc;
assign cause = i_rx_valid || i_tx_done || cfg_wr;
assign wr_dlc = cfg_wdata[19:16];

////////////////////////////////////////////////////////////////////////////////
tx_hold_a: assert property (o_tx_valid && !i_tx_done |=> o_tx_valid &&
	$stable({o_tx_center, o_tx_id, o_tx_rtr, o_tx_dlc})) else $error("frame offer changed");
tx_drop_a: assert property (o_tx_valid && i_tx_done |=> !o_tx_valid)
	else $error("offer kept after done");
remote_src_a: assert property (o_tx_valid && o_tx_rtr |-> o_tx_center inside {[1:14]})
	else $error("remote request from bad center");
tx_center_a: assert property (o_tx_valid |-> o_tx_center != 4'h0)
	else $error("offer without center");
irq_cause_a: assert property ((center_interrupt_request & ~$past(center_interrupt_request)) != 15'h0 |->
	$past(cause) || $past(cause, 2)) else $error("interrupt flag without cause");
rst_quiet_a: assert property ($past(i_reset) |->
	!o_tx_valid && center_interrupt_request == 15'h0 && gmask == 29'h1FFFFFFF) else $error("bad state after reset");
// Only the byte count is compared: flags may be set by hardware meanwhile
cfg_apply_a: assert property (cfg_wr && !i_rx_valid ##1 !i_rx_valid && $stable(cfg_sel) |=>
	rd_word[19:16] == $past(wr_dlc, 2)) else $error("byte count write lost");
rd_zero_a: assert property (rd_word[31:20] == 12'h0 && rd_word[15:13] == 3'h0)
	else $error("unused control bits set");

// Main traffic kinds
cover property (o_tx_valid && o_tx_rtr && i_tx_done);
cover property (o_tx_valid && !o_tx_rtr && i_tx_done);
cover property (i_rx_valid ##1 center_interrupt_request != 15'h0);
endmodule
`default_nettype wire

// [test/test_can_remote_frame_handler.sv]
// Self-checking bench: host and device joined, driven over AXI4-Lite and frame ports
`timescale 1ns/100ps
`default_nettype none
`include "rfh_map.svh"
module test_can_remote_frame_handler;
localparam logic [31:0] RDY = 32'h1, TRQ = 32'h2, TRANSMIT_INHIBIT = 32'h4, DUP = 32'h8, EXQ = 32'h10;
localparam logic [31:0] DIR = 32'h20, RECEIVE_SUCCESS_FLAG = 32'h40, TRANSMIT_SUCCESS_FLAG = 32'h80, RECEIVE_INTERRUPT_ENABLE = 32'h100;
localparam logic [31:0] TRANSMIT_INTERRUPT_ENABLE = 32'h200, IRQ = 32'h400, OK = 32'(`RFH_RESP_OKAY);
localparam logic [31:0] SLV = 32'(`RFH_RESP_SLVERR);
logic clk = 1'b0, rst = 1'b1;
logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
logic [7:0] awaddr = 8'h0, araddr = 8'h0;
logic [31:0] wdata = 32'h0, rdata, v;
logic awready, wready, bvalid, arready, rvalid, txv, txrtr, txext;
logic [28:0] txid;
logic [1:0] bresp, rresp;
logic rxv = 1'b0, txdone = 1'b0, txok = 1'b0, rxrtr = 1'b1;
logic [28:0] rxid = 29'h0;
logic [3:0] rxdlc = 4'h0, txc, txdlc;
int n_mismatch = 0, checks = 0, guard = 0;
rfh_if bus_if ();
always #20 clk = ~clk;

// Both ends face each other across the carrier
rfh_host rfh_host_inst (.i_clk_sys(clk), .i_reset(rst), .bus(bus_if), .i_s_awvalid(awv),
	.o_s_awready(awready), .i_s_awaddr(awaddr), .i_s_wvalid(wv), .o_s_wready(wready),
	.i_s_wdata(wdata), .i_s_wstrb(4'hF), .o_s_bvalid(bvalid), .i_s_bready(bready),
	.o_s_bresp(bresp), .i_s_arvalid(arv), .o_s_arready(arready), .i_s_araddr(araddr),
	.o_s_rvalid(rvalid), .i_s_rready(rready), .o_s_rdata(rdata), .o_s_rresp(rresp));
rfh_device rfh_device_inst (.i_clk_sys(clk), .i_reset(rst), .bus(bus_if), .i_rx_valid(rxv),
	.i_rx_id(rxid), .i_rx_ext(1'b0), .i_rx_rtr(rxrtr), .i_rx_dlc(rxdlc), .o_tx_valid(txv),
	.o_tx_center(txc), .o_tx_id(txid), .o_tx_ext(txext), .o_tx_rtr(txrtr), .o_tx_dlc(txdlc),
	.i_tx_done(txdone), .i_tx_ok(txok));
rfh_chk rfh_chk_inst (.i_clk_sys(clk), .i_reset(rst), .cfg_wr(bus_if.cfg_wr),
	.cfg_sel(bus_if.cfg_sel), .cfg_wdata(bus_if.cfg_wdata), .gmask(bus_if.gmask),
	.rd_word(bus_if.rd_word), .center_interrupt_request(bus_if.center_interrupt_request), .i_rx_valid(rxv), .i_tx_done(txdone),
	.o_tx_valid(txv), .o_tx_center(txc), .o_tx_id(txid),
	.o_tx_rtr(txrtr), .o_tx_dlc(txdlc));

////////////////////////////////////////////////////////////////////////////////
// Verdict in one place
task automatic complete_run;
	$display("Checks %0d, mismatches %0d", checks, n_mismatch);
	if (n_mismatch == 0 && checks > 0) begin
		$display("Result: passed");
	end else begin
		$display("Result: failed");
	end
	$finish;
endtask

task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
	checks++;
	if (got !== exp) begin
		n_mismatch++;
		$display("[FAIL] %s expected %h seen %h", what, exp, got);
	end
endtask

// One edge of a bounded wait; a hang ends the run
task automatic tick(input string what);
	@(posedge clk);
	guard++;
	if (guard > 300) begin
		n_mismatch++;
		$display("[FAIL] %s expected answer seen timeout", what);
		complete_run();
	end
endtask

// Address and data offered together, each dropped when taken
task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] er);
	logic ad, wd;
	ad = 1'b0;
	wd = 1'b0;
	guard = 0;
	awaddr <= a;
	wdata <= d;
	awv <= 1'b1;
	wv <= 1'b1;
	bready <= 1'b1;
	while (!(ad && wd)) begin
		tick("write");
		if (!ad && awready) begin
			ad = 1'b1;
			awv <= 1'b0;
		end
		if (!wd && wready) begin
			wd = 1'b1;
			wv <= 1'b0;
		end
	end
	while (!bvalid) tick("write response");
	bready <= 1'b0;
	chk("bresp", er, {30'h0, bresp});
	// Readback lags the write by two edges
	repeat (2) @(posedge clk);
endtask

task automatic axi_rd(input logic [7:0] a, input logic [31:0] er, output logic [31:0] d);
	guard = 0;
	araddr <= a;
	arv <= 1'b1;
	rready <= 1'b1;
	do tick("read address"); while (!arready);
	arv <= 1'b0;
	while (!rvalid) tick("read data");
	rready <= 1'b0;
	d = rdata;
	chk("rresp", er, {30'h0, rresp});
	// One edge passes so a following read does not reassign rready in this step
	@(posedge clk);
endtask

task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
	axi_rd(a, OK, v);
	chk(what, exp, v);
endtask

task automatic cfg(input logic [3:0] n, input logic [28:0] id, input logic [31:0] w);
	axi_wr(`RFH_OFF_SEL, {28'h0, n}, OK);
	axi_wr(`RFH_OFF_ID, {3'h0, id}, OK);
	axi_wr(`RFH_OFF_CTRL, w, OK);
endtask

task automatic ctl_chk(input logic [3:0] n, input logic [31:0] exp, input string what);
	axi_wr(`RFH_OFF_SEL, {28'h0, n}, OK);
	rd_chk(`RFH_OFF_CTRL, exp, what);
endtask

// Incoming frame, remote request or data, one-cycle strobe
task automatic rx(input logic [28:0] id, input logic [3:0] dlc, input logic rtr);
	rxid <= id;
	rxdlc <= dlc;
	rxrtr <= rtr;
	rxv <= 1'b1;
	@(posedge clk);
	rxv <= 1'b0;
	repeat (2) @(posedge clk);
endtask

// Waits for an offer, checks it, then ends the attempt
task automatic tx(input logic [3:0] c, input logic rtr, input logic [3:0] dlc, input logic ok,
		input logic [28:0] id);
	guard = 0;
	while (txv !== 1'b1) tick("frame offer");
	chk("tx id", {3'h0, id}, {3'h0, txid});
	chk("tx ext", 32'h0, {31'h0, txext});
	chk("tx center", {28'h0, c}, {28'h0, txc});
	chk("tx remote", {31'h0, rtr}, {31'h0, txrtr});
	chk("tx count", {28'h0, dlc}, {28'h0, txdlc});
	txok <= ok;
	txdone <= 1'b1;
	@(posedge clk);
	txdone <= 1'b0;
	repeat (2) @(posedge clk);
endtask

task automatic idle_chk(input string what);
	repeat (20) begin
		@(posedge clk);
		chk(what, 32'h0, {31'h0, txv});
	end
endtask

////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	rd_chk(`RFH_OFF_MASK, 32'h1FFFFFFF, "mask reset");
	axi_rd(8'h14, SLV, v);
	axi_wr(`RFH_OFF_INTP, 32'h0, SLV);
	cfg(4'hF, 29'h0F1, RDY | TRQ);
	cfg(4'h3, 29'h0A3, RDY | TRQ | TRANSMIT_INHIBIT | TRANSMIT_INTERRUPT_ENABLE | 32'h10000);
	cfg(4'h2, 29'h0A2, RDY | TRQ | 32'h40000);
	tx(4'h3, 1'b1, 4'h1, 1'b0, 29'h0A3);
	tx(4'h2, 1'b1, 4'h4, 1'b1, 29'h0A2);
	tx(4'h3, 1'b1, 4'h1, 1'b1, 29'h0A3);
	idle_chk("center 15 silent");
	ctl_chk(4'h3, RDY | TRANSMIT_INHIBIT | TRANSMIT_INTERRUPT_ENABLE | TRANSMIT_SUCCESS_FLAG | IRQ | 32'h10000, "center 3");
	ctl_chk(4'h2, RDY | TRANSMIT_SUCCESS_FLAG | 32'h40000, "center 2");
	rx(29'h0A2, 4'h5, 1'b0);
	ctl_chk(4'h2, RDY | TRANSMIT_SUCCESS_FLAG | RECEIVE_SUCCESS_FLAG | DUP | 32'h50000, "center 2 data");
	cfg(4'h4, 29'h123, DIR | RDY | DUP | TRANSMIT_INHIBIT | TRANSMIT_INTERRUPT_ENABLE | 32'h80000);
	cfg(4'h5, 29'h123, DIR | RDY | DUP);
	rx(29'h123, 4'h2, 1'b1);
	idle_chk("inhibit holds reply");
	ctl_chk(4'h4, DIR | RDY | DUP | TRANSMIT_INHIBIT | TRANSMIT_INTERRUPT_ENABLE | EXQ | TRQ | RECEIVE_SUCCESS_FLAG | 32'h20000, "center 4");
	ctl_chk(4'h5, DIR | RDY | DUP, "center 5");
	axi_wr(`RFH_OFF_SEL, 32'h4, OK);
	axi_wr(`RFH_OFF_CTRL, DIR | RDY | TRANSMIT_INTERRUPT_ENABLE | EXQ | TRQ | 32'h20000, OK);
	idle_chk("reply waits for update");
	axi_wr(`RFH_OFF_CTRL, DIR | RDY | DUP | TRANSMIT_INTERRUPT_ENABLE | EXQ | TRQ | 32'h20000, OK);
	tx(4'h4, 1'b0, 4'h2, 1'b1, 29'h123);
	ctl_chk(4'h4, DIR | RDY | DUP | TRANSMIT_INTERRUPT_ENABLE | TRANSMIT_SUCCESS_FLAG | IRQ | 32'h20000, "center 4 sent");
	cfg(4'h6, 29'h2AA, RDY | RECEIVE_INTERRUPT_ENABLE);
	rx(29'h2AA, 4'h3, 1'b1);
	idle_chk("receive center quiet");
	ctl_chk(4'h6, RDY | RECEIVE_INTERRUPT_ENABLE | EXQ | DUP | RECEIVE_SUCCESS_FLAG | IRQ | 32'h30000, "center 6");
	rd_chk(`RFH_OFF_ID, 32'h000002AA, "center 6 id");
	rd_chk(`RFH_OFF_INTP, 32'h2C, "interrupts");
	axi_wr(`RFH_OFF_CTRL, DIR | EXQ | 32'h30000, OK);
	axi_wr(`RFH_OFF_CTRL, DIR | RDY | TRQ | DUP | EXQ | 32'h30000, OK);
	tx(4'h6, 1'b0, 4'h3, 1'b1, 29'h2AA);
	ctl_chk(4'h6, DIR | RDY | DUP | TRANSMIT_SUCCESS_FLAG | 32'h30000, "center 6 sent");
	complete_run();
end
endmodule
`default_nettype wire
